// ### design/pmr_mgmt_regs.sv
// Purpose: Serial management slave and register set of two copper ports
// Assumes: MDC and MDIO inputs are synchronous to i_core_clk, MDC well below half its rate
// Notes:   Indices 6 and up read as zero; unmatched select addresses get no answer
`timescale 1ns/1ps
`include "pmr_consts.svh"

// Summary of operation
// - Control bit 5 picks the crossover algorithm, 1 the first and 0 the other, and resets to 1.
// - Control bit 4 forces straight pairing so the port transmits on its receive pair, reset 0.
// - Control bit 3 disables automatic crossover detection and correction, reset 0.
// - Control bit 2 disables far-end fault detection, exists on the first port only, reset 0.
// - Control bit 1 stops the transmitter and bit 0 turns the indicator LEDs off, both reset 0.
// - Status bits 14 to 11 always read 1 for the four speed and duplex abilities, bits 10 to 7 read 0.
// - Status bits 15, 6, 1 and 0 always read 0.
// - Status bit 5 shows negotiation done and bit 2 shows link up, both reset 0.
// - Status bit 4 shows a detected far-end fault on the first port only (0 on the other), is read-only and resets 0.
// - Status bit 3 shows negotiation ability, defaults 1 and follows the negotiation enable.
// - The identifier reads as two read-only words at indices 2 and 3 and ignores writes.
// - Advertisement bit 10 is writable, advertises pause when 1 and resets to 1.
// - Advertisement bits 8 to 5 are writable ability advertisements that reset to 1.
module pmr_mgmt_regs #(
    parameter logic [4:0]  PORT1_ADDR = `PMR_ADDR_PORT1,
    parameter logic [4:0]  PORT2_ADDR = `PMR_ADDR_PORT2,
    parameter logic [15:0] IDENT_HI   = 16'hA5C3, // Arbitrary value
    parameter logic [15:0] IDENT_LO   = 16'h5A10  // Arbitrary value
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_reset,
    input  wire logic             i_mdc,
    input  wire logic             i_mdio,
    output logic                  o_mdio_out,
    output logic                  o_mdio_oe,
    input  wire logic [1:0]       i_link_up,
    input  wire logic [1:0]       i_negotiation_done,
    input  wire logic             i_far_end_fault,
    input  wire logic [1:0]       i_negotiation_enable,
    input  wire logic [1:0][4:0]  i_partner_ability,
    input  wire logic             i_sw_wr,
    input  wire logic             i_sw_port,
    input  wire logic             i_sw_sel,
    input  wire logic [15:0]      i_sw_wdata,
    output logic      [1:0][5:0]  o_port_control,
    output logic      [1:0][4:0]  o_port_advert
);

    pmr_pkg::pmr_top_state_s st_reg;
    pmr_pkg::pmr_top_state_s st_next;

    logic [1:0][15:0] rdata;
    logic             mdc_rise;
    logic [12:0]      hdr;
    logic [4:0]       rd_idx;
    logic             p1_hit;
    logic             p2_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Header decode
    assign mdc_rise = i_mdc && !st_reg.mdc_q;
    assign hdr      = {st_reg.sh[11:0], i_mdio};
    assign p1_hit   = hdr[9:5] == PORT1_ADDR;
    assign p2_hit   = hdr[9:5] == PORT2_ADDR;
    assign rd_idx   = (st_reg.frame == pmr_pkg::PMR_HDR) ? hdr[4:0] : st_reg.idx;

    ////////////////////////////////////////////////////////////////////////////
    // Frame engine
    always_comb begin
        st_next       = st_reg;
        st_next.mdc_q = i_mdc;
        st_next.wr    = 2'b00;
        if (mdc_rise) begin
            unique case (st_reg.frame)
                pmr_pkg::PMR_IDLE: begin
                    if (i_mdio) begin
                        if (st_reg.ones != `PMR_PREAMBLE_LEN) begin
                            st_next.ones = st_reg.ones + 6'h01;
                        end
                    end else if (st_reg.ones == `PMR_PREAMBLE_LEN) begin
                        st_next.frame = pmr_pkg::PMR_HDR;
                        st_next.cnt   = 5'h00;
                        st_next.sh    = 16'h0000;
                    end else begin
                        st_next.ones = 6'h00;
                    end
                end
                pmr_pkg::PMR_HDR: begin
                    st_next.sh  = {st_reg.sh[14:0], i_mdio};
                    st_next.cnt = st_reg.cnt + 5'h01;
                    if (st_reg.cnt == `PMR_HDR_LAST) begin
                        st_next.ones    = 6'h00;
                        st_next.is_read = hdr[11:10] == `PMR_OP_READ;
                        st_next.hit     = p1_hit || p2_hit;
                        st_next.port    = p2_hit && !p1_hit;
                        st_next.idx     = hdr[4:0];
                        st_next.sh      = rdata[p2_hit && !p1_hit];
                        st_next.cnt     = 5'h00;
                        if (hdr[12] && (hdr[11:10] == `PMR_OP_READ || hdr[11:10] == `PMR_OP_WRITE)) begin
                            st_next.frame = pmr_pkg::PMR_TA;
                        end else begin
                            st_next.frame = pmr_pkg::PMR_IDLE;
                        end
                    end
                end
                pmr_pkg::PMR_TA: begin
                    st_next.cnt = st_reg.cnt + 5'h01;
                    if (st_reg.cnt == 5'h00) begin
                        st_next.mdio_out = 1'b0;
                        st_next.mdio_oe  = st_reg.is_read && st_reg.hit;
                    end else begin
                        st_next.mdio_out = st_reg.sh[15];
                        st_next.sh       = {st_reg.sh[14:0], 1'b0};
                        st_next.cnt      = 5'h00;
                        st_next.frame    = pmr_pkg::PMR_DATA;
                    end
                end
                pmr_pkg::PMR_DATA: begin
                    st_next.cnt = st_reg.cnt + 5'h01;
                    if (st_reg.is_read) begin
                        st_next.mdio_out = st_reg.sh[15];
                        st_next.sh       = {st_reg.sh[14:0], 1'b0};
                    end else begin
                        st_next.sh = {st_reg.sh[14:0], i_mdio};
                    end
                    if (st_reg.cnt == `PMR_DATA_LAST) begin
                        st_next.frame    = pmr_pkg::PMR_IDLE;
                        st_next.mdio_oe  = 1'b0;
                        st_next.mdio_out = 1'b0;
                        st_next.cnt      = 5'h00;
                        st_next.wdata    = {st_reg.sh[14:0], i_mdio};
                        if (!st_reg.is_read && st_reg.hit) begin
                            st_next.wr[st_reg.port] = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            st_reg       <= '0;
            st_reg.frame <= pmr_pkg::PMR_IDLE;
            st_reg.mdc_q <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_mdio_out = st_reg.mdio_out;
    assign o_mdio_oe  = st_reg.mdio_oe;

    ////////////////////////////////////////////////////////////////////////////
    // Port register sets
    for (genvar p = 0; p < 2; p++) begin : g_port
        pmr_port_regs #(
            .HAS_FEF  (p == 0),
            .IDENT_HI (IDENT_HI),
            .IDENT_LO (IDENT_LO)
        ) u_port (
            .i_core_clk           (i_core_clk),
            .i_reset              (i_reset),
            .i_mg_wr              (st_reg.wr[p]),
            .i_mg_idx             (st_reg.idx),
            .i_mg_wdata           (st_reg.wdata),
            .i_sw_wr              (i_sw_wr && (i_sw_port == 1'(p))),
            .i_sw_sel             (i_sw_sel),
            .i_sw_wdata           (i_sw_wdata),
            .i_rd_idx             (rd_idx),
            .i_link_up            (i_link_up[p]),
            .i_negotiation_done   (i_negotiation_done[p]),
            .i_far_end_fault      (i_far_end_fault),
            .i_negotiation_enable (i_negotiation_enable[p]),
            .i_partner_ability    (i_partner_ability[p]),
            .o_rdata              (rdata[p]),
            .o_control            (o_port_control[p]),
            .o_advert             (o_port_advert[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_ta_zero;
        @(posedge i_core_clk) disable iff (i_reset)
        $rose(o_mdio_oe) |-> !o_mdio_out && st_reg.is_read && st_reg.hit && st_reg.frame == pmr_pkg::PMR_TA;
    endproperty
    a_ta_zero: assert property (p_ta_zero) else $error("turnaround drive wrong");

    property p_ident_wr;
        @(posedge i_core_clk) disable iff (i_reset)
        st_reg.wr != 2'b00 && (st_reg.idx == `PMR_IDX_ID_HI || st_reg.idx == `PMR_IDX_ID_LO)
            |=> rdata[0][15:0] == ((rd_idx == `PMR_IDX_ID_HI) ? IDENT_HI :
                (rd_idx == `PMR_IDX_ID_LO) ? IDENT_LO : rdata[0]);
    endproperty
    a_ident_wr: assert property (p_ident_wr) else $error("ident changed by write");

endmodule // pmr_mgmt_regs

// ### design/pmr_consts.svh
// Purpose: Named constants of the transceiver management register set
// Assumes: Included by the package and by every design file that decodes registers
// Notes:   Indices are 5-bit register numbers of the serial management frame
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH

// Register indices
`define PMR_IDX_CTRL       5'h00
`define PMR_IDX_STAT       5'h01
`define PMR_IDX_ID_HI      5'h02
`define PMR_IDX_ID_LO      5'h03
`define PMR_IDX_ADV        5'h04
`define PMR_IDX_LPA        5'h05

// Default transceiver select addresses
`define PMR_ADDR_PORT1     5'h01
`define PMR_ADDR_PORT2     5'h02

// Control field: bits 5..0 held, bit 5 resets high
`define PMR_CTRL_MSB       5
`define PMR_CTRL_RST       6'h20
`define PMR_CTRL_FEF_MASK  6'h3B
`define PMR_CTRL_XOVER     5
`define PMR_CTRL_STRAIGHT  4
`define PMR_CTRL_NOXOVER   3
`define PMR_CTRL_NOFEF     2
`define PMR_CTRL_NOTX      1
`define PMR_CTRL_NOLED     0

// Advertisement: held field is {pause, 100F, 100H, 10F, 10H}
`define PMR_ADV_RST        5'h1F
`define PMR_ADV_PAUSE      10
`define PMR_ADV_ABIL_MSB   8
`define PMR_ADV_ABIL_LSB   5
`define PMR_SELECTOR       5'h01

// Status word constant parts and live bit positions
`define PMR_STAT_ABIL      4'hF
`define PMR_STAT_ABIL_MSB  14
`define PMR_STAT_ABIL_LSB  11
`define PMR_STAT_ZERO_MSB  10
`define PMR_STAT_ZERO_LSB  7
`define PMR_STAT_T4        15
`define PMR_STAT_PRE       6
`define PMR_STAT_DONE      5
`define PMR_STAT_FEF       4
`define PMR_STAT_ABLE      3
`define PMR_STAT_LINK      2
`define PMR_STAT_JAB       1
`define PMR_STAT_EXT       0

// Serial frame
`define PMR_PREAMBLE_LEN   6'h20
`define PMR_OP_READ        2'h2
`define PMR_OP_WRITE       2'h1
`define PMR_HDR_LAST       5'h0C
`define PMR_DATA_LAST      5'h0F

`endif

// ### design/pmr_pkg.sv
// Purpose: Types shared by the management register set
// Assumes: Constants come from pmr_consts.svh
// Notes:   Holds state types only
`include "pmr_consts.svh"

package pmr_pkg;

    typedef enum logic [1:0] {
        PMR_IDLE,
        PMR_HDR,
        PMR_TA,
        PMR_DATA
    } pmr_frame_e;

    typedef struct packed {
        logic [5:0] ctrl;
        logic [4:0] adv;
        logic       link;
        logic       done;
        logic       fef;
        logic       able;
        logic [4:0] lpa;
    } pmr_port_state_s;

    typedef struct packed {
        logic       mdc_q;
        pmr_frame_e frame;
        logic [5:0] ones;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic       is_read;
        logic       hit;
        logic       port;
        logic [4:0] idx;
        logic       mdio_out;
        logic       mdio_oe;
        logic [1:0] wr;
        logic [15:0] wdata;
    } pmr_top_state_s;

endpackage

// ### design/pmr_port_regs.sv
// Purpose: Register storage and read word of one transceiver port
// Assumes: Management writes and switch-side writes share the same storage
// Notes:   Management write wins when both arrive in one cycle
`timescale 1ns/1ps
`include "pmr_consts.svh"

module pmr_port_regs #(
    parameter bit          HAS_FEF  = 1'b1,
    parameter logic [15:0] IDENT_HI = 16'h0000,
    parameter logic [15:0] IDENT_LO = 16'h0000
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    input  wire logic        i_mg_wr,
    input  wire logic [4:0]  i_mg_idx,
    input  wire logic [15:0] i_mg_wdata,
    input  wire logic        i_sw_wr,
    input  wire logic        i_sw_sel,
    input  wire logic [15:0] i_sw_wdata,
    input  wire logic [4:0]  i_rd_idx,
    input  wire logic        i_link_up,
    input  wire logic        i_negotiation_done,
    input  wire logic        i_far_end_fault,
    input  wire logic        i_negotiation_enable,
    input  wire logic [4:0]  i_partner_ability,
    output logic      [15:0] o_rdata,
    output logic      [5:0]  o_control,
    output logic      [4:0]  o_advert
);

    pmr_pkg::pmr_port_state_s st_reg;
    pmr_pkg::pmr_port_state_s st_next;

    function automatic logic [5:0] ctrl_field(input logic [15:0] d);
        ctrl_field = HAS_FEF ? d[`PMR_CTRL_MSB:0] : (d[`PMR_CTRL_MSB:0] & `PMR_CTRL_FEF_MASK);
    endfunction

    function automatic logic [4:0] adv_field(input logic [15:0] d);
        adv_field = {d[`PMR_ADV_PAUSE], d[`PMR_ADV_ABIL_MSB:`PMR_ADV_ABIL_LSB]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next      = st_reg;
        st_next.link = i_link_up;
        st_next.done = i_negotiation_done;
        st_next.fef  = HAS_FEF ? i_far_end_fault : 1'b0;
        st_next.able = i_negotiation_enable;
        st_next.lpa  = i_partner_ability;
        if (i_mg_wr) begin
            if (i_mg_idx == `PMR_IDX_CTRL) begin
                st_next.ctrl = ctrl_field(i_mg_wdata);
            end else if (i_mg_idx == `PMR_IDX_ADV) begin
                st_next.adv = adv_field(i_mg_wdata);
            end
        end else if (i_sw_wr) begin
            if (i_sw_sel) begin
                st_next.adv = adv_field(i_sw_wdata);
            end else begin
                st_next.ctrl = ctrl_field(i_sw_wdata);
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            st_reg      <= '0;
            st_reg.ctrl <= `PMR_CTRL_RST;
            st_reg.adv  <= `PMR_ADV_RST;
            st_reg.able <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read word
    always_comb begin
        o_rdata = 16'h0000;
        unique case (i_rd_idx)
            `PMR_IDX_CTRL:  o_rdata[`PMR_CTRL_MSB:0] = st_reg.ctrl;
            `PMR_IDX_STAT: begin
                o_rdata[`PMR_STAT_ABIL_MSB:`PMR_STAT_ABIL_LSB] = `PMR_STAT_ABIL;
                o_rdata[`PMR_STAT_DONE] = st_reg.done;
                o_rdata[`PMR_STAT_FEF]  = st_reg.fef;
                o_rdata[`PMR_STAT_ABLE] = st_reg.able;
                o_rdata[`PMR_STAT_LINK] = st_reg.link;
            end
            `PMR_IDX_ID_HI: o_rdata = IDENT_HI;
            `PMR_IDX_ID_LO: o_rdata = IDENT_LO;
            `PMR_IDX_ADV: begin
                o_rdata[`PMR_ADV_PAUSE] = st_reg.adv[4];
                o_rdata[`PMR_ADV_ABIL_MSB:`PMR_ADV_ABIL_LSB] = st_reg.adv[3:0];
                o_rdata[4:0] = `PMR_SELECTOR;
            end
            `PMR_IDX_LPA: begin
                o_rdata[`PMR_ADV_PAUSE] = st_reg.lpa[4];
                o_rdata[`PMR_ADV_ABIL_MSB:`PMR_ADV_ABIL_LSB] = st_reg.lpa[3:0];
            end
            default:        o_rdata = 16'h0000;
        endcase
    end

    assign o_control = st_reg.ctrl;
    assign o_advert  = st_reg.adv;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    property p_xover_sel;
        i_mg_wr && i_mg_idx == `PMR_IDX_CTRL |=> o_control[`PMR_CTRL_XOVER] == $past(i_mg_wdata[`PMR_CTRL_XOVER]);
    endproperty
    a_xover_sel: assert property (p_xover_sel) else $error("crossover select not written");

    property p_straight;
        !i_mg_wr && i_sw_wr && !i_sw_sel |=> o_control[`PMR_CTRL_STRAIGHT] == $past(i_sw_wdata[`PMR_CTRL_STRAIGHT]);
    endproperty
    a_straight: assert property (p_straight) else $error("straight pairing not written by switch");

    property p_noxover_hold;
        $changed(o_control[`PMR_CTRL_NOXOVER]) |-> $past(i_mg_wr || i_sw_wr);
    endproperty
    a_noxover_hold: assert property (p_noxover_hold) else $error("crossover disable changed alone");

    property p_fef_port;
        !HAS_FEF |-> o_control[`PMR_CTRL_NOFEF] == 1'b0
            && (i_rd_idx != `PMR_IDX_STAT || o_rdata[`PMR_STAT_FEF] == 1'b0);
    endproperty
    a_fef_port: assert property (p_fef_port) else $error("fault control on second port");

    property p_reset_ctrl;
        $past(i_reset) |-> o_control == `PMR_CTRL_RST && o_advert == `PMR_ADV_RST;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("control or advert reset value wrong");

    property p_stat_const;
        i_rd_idx == `PMR_IDX_STAT |-> o_rdata[`PMR_STAT_ABIL_MSB:`PMR_STAT_ZERO_LSB] == {`PMR_STAT_ABIL, 4'h0};
    endproperty
    a_stat_const: assert property (p_stat_const) else $error("ability bits wrong");

    property p_stat_zero;
        i_rd_idx == `PMR_IDX_STAT |-> !o_rdata[`PMR_STAT_T4] && !o_rdata[`PMR_STAT_PRE]
            && !o_rdata[`PMR_STAT_JAB] && !o_rdata[`PMR_STAT_EXT];
    endproperty
    a_stat_zero: assert property (p_stat_zero) else $error("unsupported status bit set");

    property p_link;
        i_rd_idx == `PMR_IDX_STAT ##1 i_rd_idx == `PMR_IDX_STAT
            |-> o_rdata[`PMR_STAT_LINK] == $past(i_link_up) && o_rdata[`PMR_STAT_DONE] == $past(i_negotiation_done);
    endproperty
    a_link: assert property (p_link) else $error("link or done status stale");

    property p_able;
        i_rd_idx == `PMR_IDX_STAT |-> o_rdata[`PMR_STAT_ABLE] == $past(i_negotiation_enable, 1);
    endproperty
    a_able: assert property (p_able) else $error("able bit does not follow enable");

    property p_ident;
        i_rd_idx == `PMR_IDX_ID_LO |-> o_rdata == IDENT_LO;
    endproperty
    a_ident: assert property (p_ident) else $error("ident low word wrong");

    property p_adv_write;
        i_mg_wr && i_mg_idx == `PMR_IDX_ADV ##1 i_rd_idx == `PMR_IDX_ADV
            |-> o_rdata == {5'h00, $past(i_mg_wdata[`PMR_ADV_PAUSE]), 1'b0,
                            $past(i_mg_wdata[`PMR_ADV_ABIL_MSB:`PMR_ADV_ABIL_LSB]), `PMR_SELECTOR};
    endproperty
    a_adv_write: assert property (p_adv_write) else $error("advert read-back wrong");

endmodule // pmr_port_regs

// ### verif/pmr_station.sv
// Purpose: Management station model driving serial frames into the register set
// Assumes: MDC period of four core cycles, line pulled up when released
// Notes:   Read words are handed to the bench with a one-cycle strobe
`timescale 1ns/1ps
`include "pmr_consts.svh"

module pmr_station (
    input  wire logic        i_core_clk,
    input  wire logic        i_mdio,
    output logic             o_mdc,
    output logic             o_mdio,
    output logic             o_mdio_oe,
    output logic             o_rd_stb,
    output logic      [15:0] o_rd_word
);
    initial begin
        {o_mdc, o_mdio, o_mdio_oe, o_rd_stb, o_rd_word} = 20'h00000;
    end

    // One MDC period; line sampled just before the rise
    task automatic bit_cyc(input logic b, input logic en, output logic s);
        o_mdio    = b;
        o_mdio_oe = en;
        o_mdc     = 1'b0;
        repeat (2) @(posedge i_core_clk);
        #2;
        s     = i_mdio;
        o_mdc = 1'b1;
        repeat (2) @(posedge i_core_clk);
        #2;
    endtask

    task automatic frame(input logic [4:0] addr, input logic [4:0] idx, input logic rd, input logic [15:0] wd);
        logic [31:0] hdr;
        logic [15:0] w;
        logic        s;
        hdr = {2'b01, rd ? `PMR_OP_READ : `PMR_OP_WRITE, addr, idx, 2'b10, wd};
        w   = 16'h0000;
        for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            bit_cyc(hdr[i], !(rd && i < 18), s);
            if (rd && i < 16) w[i] = s;
        end
        // Extra rise with the line released, the device having let go at the last data rise; MDC then stands still
        bit_cyc(1'b1, 1'b0, s);
        if (rd) begin
            o_rd_word = w;
            o_rd_stb  = 1'b1;
            @(posedge i_core_clk);
            #2 o_rd_stb = 1'b0;
        end
    endtask
endmodule // pmr_station

// ### verif/pmr_mgmt_regs_tb_top.sv
// Purpose: Self-checking bench of the management register set
// Assumes: Station model on the serial side, bench on the switch side
// Notes:   Expected read words queue up and are matched when the station strobes
`timescale 1ns/1ps
`include "pmr_consts.svh"

module pmr_mgmt_regs_tb_top;
    localparam logic [15:0] IDH = 16'h3C5A; // Arbitrary value
    localparam logic [15:0] IDL = 16'h7E21; // Arbitrary value
    logic            core_clk, rst, mdc, sta_d, sta_oe, dut_out, dut_oe, rd_stb, mdio_w;
    logic            sw_wr, sw_port, sw_sel, fef;
    logic [1:0]      link, done, ane;
    logic [1:0][4:0] pa, adv;
    logic [1:0][5:0] ctl;
    logic [15:0]     rd_word, sw_wd;
    logic [15:0]     exp_q[$];
    int              n_errors, checks, cyc;

    assign mdio_w = dut_oe ? dut_out : (sta_oe ? sta_d : 1'b1);

    pmr_mgmt_regs #(.IDENT_HI(IDH), .IDENT_LO(IDL)) u_dut (.i_core_clk(core_clk), .i_reset(rst),
        .i_mdc(mdc), .i_mdio(mdio_w), .o_mdio_out(dut_out), .o_mdio_oe(dut_oe), .i_link_up(link),
        .i_negotiation_done(done), .i_far_end_fault(fef), .i_negotiation_enable(ane),
        .i_partner_ability(pa), .i_sw_wr(sw_wr), .i_sw_port(sw_port), .i_sw_sel(sw_sel),
        .i_sw_wdata(sw_wd), .o_port_control(ctl), .o_port_advert(adv));
    pmr_station u_sta (.i_core_clk(core_clk), .i_mdio(mdio_w), .o_mdc(mdc), .o_mdio(sta_d),
        .o_mdio_oe(sta_oe), .o_rd_stb(rd_stb), .o_rd_word(rd_word));

    task automatic tally_and_finish();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp_word(input logic [15:0] e, input logic [15:0] a);
        checks++;
        if (a !== e) begin
            n_errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic cmp_port(input logic [5:0] e, input logic [5:0] a);
        checks++;
        if (a !== e) begin
            n_errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [4:0] i, input logic [15:0] e);
        exp_q.push_back(e);
        u_sta.frame(a, i, 1'b1, 16'h0000);
    endtask
    task automatic sw(input logic p, input logic s, input logic [15:0] d);
        @(posedge core_clk);
        #2 {sw_wr, sw_port, sw_sel, sw_wd} = {1'b1, p, s, d};
        @(posedge core_clk);
        #2 sw_wr = 1'b0;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            tally_and_finish();
        end
        if (rd_stb === 1'b1) begin
            if (exp_q.size() == 0) cmp_word(16'hDEAD, rd_word);
            else cmp_word(exp_q.pop_front(), rd_word);
        end
    end

    initial begin : main
        logic [15:0] w;
        logic [5:0]  m;
        logic [4:0]  a;
        {rst, sw_wr, sw_port, sw_sel, sw_wd, link, done, fef, ane, pa} = 37'h1000000000;
        void'($urandom(16456));
        repeat (16) @(posedge core_clk);
        #2 rst = 1'b0;
        for (int p = 0; p < 2; p++) begin
            a = p ? `PMR_ADDR_PORT2 : `PMR_ADDR_PORT1;
            m = p ? `PMR_CTRL_FEF_MASK : 6'h3F;
            rd(a, `PMR_IDX_CTRL, 16'h0020);
            rd(a, `PMR_IDX_ADV, 16'h05E1);
            u_sta.frame(a, `PMR_IDX_ID_HI, 1'b0, 16'($urandom));
            rd(a, `PMR_IDX_ID_HI, IDH);
            rd(a, `PMR_IDX_ID_LO, IDL);
            for (int j = 0; j < 2; j++) begin
                w = j ? ~w : 16'($urandom);
                {link, done, ane, fef, pa} = {w[6:0], w[15:6]};
                rd(a, `PMR_IDX_STAT, {5'h0F, 5'h00, done[p], p ? 1'b0 : fef, ane[p], link[p], 2'b00});
                rd(a, `PMR_IDX_LPA, {5'h00, pa[p][4], 1'b0, pa[p][3:0], 5'h00});
            end
            w = 16'($urandom);
            u_sta.frame(a, `PMR_IDX_CTRL, 1'b0, w);
            rd(a, `PMR_IDX_CTRL, {10'h000, w[5:0] & m});
            cmp_port(w[5:0] & m, ctl[p]);
            u_sta.frame(a, `PMR_IDX_ADV, 1'b0, w);
            rd(a, `PMR_IDX_ADV, {5'h00, w[10], 1'b0, w[8:5], `PMR_SELECTOR});
            cmp_port({1'b0, w[10], w[8:5]}, adv[p]);
            rd(a, 5'h1D, 16'h0000);
            rd(a, 5'h06, 16'h0000);
            w = 16'($urandom);
            sw(p[0], 1'b0, w);
            cmp_port(w[5:0] & m, ctl[p]);
            rd(a, `PMR_IDX_CTRL, {10'h000, w[5:0] & m});
            sw(p[0], 1'b1, ~w);
            rd(a, `PMR_IDX_ADV, {5'h00, ~w[10], 1'b0, ~w[8:5], `PMR_SELECTOR});
        end
        rd(5'h03, `PMR_IDX_CTRL, 16'hFFFF);
        rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #2 rst = 1'b0;
        for (int p = 0; p < 2; p++) begin
            cmp_port(6'h20, ctl[p]);
            cmp_port({1'b0, `PMR_ADV_RST}, adv[p]);
        end
        repeat (4) @(posedge core_clk);
        if (exp_q.size() != 0) n_errors++;
        tally_and_finish();
    end
endmodule // pmr_mgmt_regs_tb_top
